// ==== listen_and_auto_mode_sequencer_bench.sv ====
// Self-checking bench for both ends of the mode sequencer
module listen_and_auto_mode_sequencer_bench
  import mode_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sig, sync, done, qlev, sent, chk, qdata, tick, sdata, bit_d;
  logic [2:0] tcnt, active_mode;
  logic rx_rdy, listen_active, timeout_irq, fifo_discard, cal_done;
  int failures, num_checks;
  mode_seq_if link ();
  mode_seq_host i_mode_seq_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link.host));
  mode_seq_device #(.CAL_CYC(16)) i_mode_seq_device (.pclk, .presetn, .link(link.device),
    .signal_above_limit(sig), .sync_word_matched(sync), .payload_complete_flag(done),
    .queue_level_flag(qlev), .frame_sent_flag(sent), .check_passed_flag(chk),
    .queue_has_data(qdata), .bit_tick(tick), .rx_bit(tcnt[2]), .active_mode,
    .receiver_ready_flag(rx_rdy), .serial_data_pin(sdata), .listen_active, .timeout_irq,
    .fifo_discard, .osc_cal_finished(cal_done));
  mode_seq_checker #(.CAL_CYC(16)) i_mode_seq_checker (.pclk, .presetn,
    .wr_req(link.wr_req), .rd_req(link.rd_req), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .active_mode, .receiver_ready_flag(rx_rdy), .listen_active,
    .timeout_irq, .fifo_discard, .osc_cal_finished(cal_done));
  // ***************************************************************
  // Clock, bit tick and shared tasks
  // ***************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // One bit every 8 clocks keeps the sixteen-bit timeout steps short
  always @(posedge pclk) begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7);
    bit_d <= tcnt[2];
  end
  task complete_run;
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends on pready; only the watchdog ends this wait if pready never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    check("pready", pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_mode(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (active_mode !== m && n < lim) begin
      @(negedge pclk);
      n++;
    end
    check("active_mode", active_mode, m);
  endtask : wait_mode
  task fire(input logic [1:0] c);
    @(posedge pclk);
    case (c)
      TRIG_LEVEL: qlev <= 1'b1;
      TRIG_SENT: sent <= 1'b1;
      TRIG_CHECK: chk <= 1'b1;
      default: qdata <= 1'b0;
    endcase
    @(posedge pclk);
    {qlev, sent, chk, qdata} <= 4'b0001;
  endtask : fire
  function automatic logic [31:0] lcfg(input logic acc, input logic [1:0] e);
    return 32'h00050101 | {9'h0, e, acc, 20'h0};
  endfunction : lcfg
  task enter_listen(input logic [31:0] cfg);
    apb(1'b1, OFS_LISTEN, cfg);
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_MODE, 32'h9);
    wait_mode(MODE_SLEEP, 10);
    check("listen", listen_active, 1'b1);
    wait_mode(MODE_RX, 8100);
  endtask : enter_listen
  task abort_to(input logic [2:0] m);
    apb(1'b1, OFS_MODE, {27'h0, 2'b10, m});
    @(negedge pclk);
    check("abort_mode", active_mode, m);
    check("abort_listen", listen_active, 1'b0);
    apb(1'b1, OFS_MODE, {29'h0, m});
  endtask : abort_to
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task reset_values;
    apb(1'b0, OFS_STATUS, 32'h0);
    check("cal_done", rd[ST_CAL_DONE_BIT], 1'b1);
    apb(1'b0, OFS_MODE, 32'h0);
    check("mode_reg", rd, RESET_MODE_REG);
    apb(1'b0, OFS_LISTEN, 32'h0);
    check("listen_reg", rd, RESET_LISTEN_REG);
    apb(1'b1, 12'h100, 32'hffffffff);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", rd, 32'h0);
    apb(1'b1, OFS_OSC, 32'h1);
    check("recal_busy", cal_done, 1'b0);
    repeat (30) @(posedge pclk);
    check("recal", cal_done, 1'b1);
  endtask : reset_values
  task mode_codes;
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, OFS_MODE, m);
      wait_mode(m[2:0], 60);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status_mode", rd[6:4], m[2:0]);
    end
  endtask : mode_codes
  task hops;
    apb(1'b1, OFS_MODE, 32'h3);
    apb(1'b1, OFS_MODE, 32'h4);
    apb(1'b1, OFS_FREQ, 32'h00e4c000);
    apb(1'b1, OFS_MODE, 32'h3);
    wait_mode(MODE_TX, 10);
    apb(1'b0, OFS_FREQ, 32'h0);
    check("tx_hop", rd, 32'h00e4c000);
    apb(1'b1, OFS_MODE, 32'h4);
    apb(1'b1, OFS_FREQ, 32'h00d90000);
    apb(1'b1, OFS_MODE, 32'h2);
    apb(1'b1, OFS_MODE, 32'h4);
    wait_mode(MODE_RX, 10);
    check("hop_ready", rx_rdy, 1'b1);
    apb(1'b0, OFS_FREQ, 32'h0);
    check("rx_hop", rd, 32'h00d90000);
    apb(1'b1, OFS_MODE, 32'h1);
  endtask : hops
  task listen_reject;
    sig <= 1'b1;
    enter_listen(lcfg(1'b1, END_RESUME));
    repeat (7900) @(posedge pclk);
    check("rx_window", active_mode, MODE_RX);
    wait_mode(MODE_SLEEP, 300);
    check("still_listen", listen_active, 1'b1);
    abort_to(MODE_STANDBY);
  endtask : listen_reject
  task listen_resume;
    enter_listen(lcfg(1'b0, END_RESUME));
    repeat (8200) @(posedge pclk);
    check("kept_rx", active_mode, MODE_RX);
    @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
    wait_mode(MODE_SLEEP, 20);
    check("resumed", listen_active, 1'b1);
    abort_to(MODE_SLEEP);
  endtask : listen_resume
  task listen_stay;
    enter_listen(lcfg(1'b0, END_STAY));
    repeat (8200) @(posedge pclk);
    check("stay_rx", active_mode, MODE_RX);
    // Bit synchroniser is off in this set-up, so data follow the input bit
    repeat (8) begin
      @(negedge pclk);
      check("data_out", sdata, bit_d);
    end
    abort_to(MODE_STANDBY);
  endtask : listen_stay
  task listen_go_mode;
    int n;
    apb(1'b1, OFS_TIMEOUT, 32'h1);
    enter_listen(lcfg(1'b0, END_GO_MODE));
    n = 0;
    while (timeout_irq !== 1'b1 && n < 300) begin
      @(negedge pclk);
      n++;
    end
    check("timeout_at", n inside {[112:160]}, 1'b1);
    wait_mode(MODE_STANDBY, 10);
    check("stopped", listen_active, 1'b0);
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_TIMEOUT, 32'h0);
    sig <= 1'b0;
  endtask : listen_go_mode
  task auto_modes;
    logic [2:0] base [2] = '{MODE_SLEEP, MODE_RX};
    logic [2:0] tm [2] = '{MODE_TX, MODE_SLEEP};
    logic [1:0] en [2] = '{TRIG_LEVEL, TRIG_CHECK};
    logic [1:0] ex [2] = '{TRIG_SENT, TRIG_EMPTIED};
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_AUTO, {24'h0, 1'b1, tm[i], ex[i], en[i]});
      apb(1'b1, OFS_MODE, {29'h0, base[i]});
      wait_mode(base[i], 60);
      fire(en[i]);
      wait_mode(tm[i], 60);
      if (i == 0) begin
        apb(1'b1, OFS_MODE, 32'h1);
        check("in_transit", active_mode, tm[i]);
      end
      fire(ex[i]);
      wait_mode(i == 0 ? MODE_STANDBY : base[i], 60);
    end
    apb(1'b1, OFS_AUTO, 32'h0);
  endtask : auto_modes
  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial begin
    {presetn, psel, penable, pwrite, sig, sync, done, qlev, sent, chk} = 10'h0;
    {paddr, pwdata, tcnt, tick, qdata} = {44'h0, 3'h0, 1'b0, 1'b1};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (24) @(posedge pclk);
    reset_values;
    mode_codes;
    hops;
    listen_reject;
    listen_resume;
    listen_stay;
    listen_go_mode;
    auto_modes;
    complete_run;
  end
  // The listen scenarios need some 60000 cycles in all
  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    complete_run;
  end
endmodule : listen_and_auto_mode_sequencer_bench

// ==== mode_seq_checker.sv ====
// Assertions on the link and the device outputs of the mode sequencer
module mode_seq_checker
  import mode_seq_pkg::*;
#(
  parameter int CAL_CYC = CAL_CYC_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_req,
  input wire logic rd_req,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [2:0] active_mode,
  input wire logic receiver_ready_flag,
  input wire logic listen_active,
  input wire logic timeout_irq,
  input wire logic fifo_discard,
  input wire logic osc_cal_finished
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Saturates so a long run never wraps back into the calibration window
  logic [15:0] since_rst;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_rst <= 16'h0;
    else if (since_rst != 16'hffff) since_rst <= since_rst + 16'h1;
  end
  sequence s_mode_wr;
    wr_req && ack && addr == OFS_MODE;
  endsequence
  property p_ack_one;
    ack |=> !ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("link ack too long");
  property p_ack_time;
    $rose(wr_req || rd_req) |=> ack;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("link ack late");
  property p_rx_ready;
    receiver_ready_flag == (active_mode == MODE_RX);
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("rx ready wrong");
  property p_abort;
    logic [2:0] m;
    (s_mode_wr ##0 (wdata[ABORT_BIT], m = wdata[2:0])) |-> ##[1:3] (!listen_active && active_mode == m);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");
  property p_listen_in;
    (s_mode_wr ##0 wdata[5:0] == 6'h09) |-> ##[1:4] listen_active;
  endproperty
  a_listen_in: assert property (p_listen_in) else $error("listen not entered");
  property p_discard;
    fifo_discard |-> ##[0:2] active_mode == MODE_RX;
  endproperty
  a_discard: assert property (p_discard) else $error("discard outside rx");
  property p_timeout_one;
    timeout_irq |=> !timeout_irq;
  endproperty
  a_timeout_one: assert property (p_timeout_one) else $error("timeout too long");
  property p_cal_low;
    since_rst < CAL_CYC - 2 |-> !osc_cal_finished;
  endproperty
  a_cal_low: assert property (p_cal_low) else $error("cal done early");
  property p_cal_high;
    since_rst == CAL_CYC + 4 |-> osc_cal_finished;
  endproperty
  a_cal_high: assert property (p_cal_high) else $error("cal done late");
endmodule : mode_seq_checker

// ==== mode_seq_device.sv ====
// Device end: listen engine, auto transit and mode registers
// Summary of operation
// - Bit timing locks after twelve preamble bits
// - No bitsync, no packet mode: data valid at receiver ready
// - Transmit hop: rx, new freq, tx
// - Receive hop: new freq, synth, rx
// - Hop sequences assume sequencer enabled
// - Listen starts when enabled from standby
// - Idle, periodic receive, keep if wanted
// - Receive window includes receiver wake-up
// - Phase time is multiplier times base
// - Base codes 64us, 4.1ms, 262ms
// - Accept on level, optionally sync match
// - End 00: stay receive, stop listen
// - End 01: until done, then mode
// - End 10: until done, resume idle
// - Abort: write abort set, then cleared
// - Oscillator calibrates itself after reset
// - Calibration request sets finished flag
// - Auto mode enters, exits transit state
// - Mode rewritten in transit used on exit
// - Triggers: level, sent, check, emptied
// - Mode codes; listen overrides mode field
// - Timeout counts steps of sixteen bits
module mode_seq_device
  import mode_seq_pkg::*;
#(
  parameter int CAL_CYC = CAL_CYC_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  mode_seq_if.device link,
  input wire logic signal_above_limit,
  input wire logic sync_word_matched,
  input wire logic payload_complete_flag,
  input wire logic queue_level_flag,
  input wire logic frame_sent_flag,
  input wire logic check_passed_flag,
  input wire logic queue_has_data,
  input wire logic bit_tick,
  input wire logic rx_bit,
  output logic [2:0] active_mode,
  output logic receiver_ready_flag,
  output logic serial_data_pin,
  output logic listen_active,
  output logic timeout_irq,
  output logic fifo_discard,
  output logic osc_cal_finished
);
  // ***************************************************************
  // Types and state
  // ***************************************************************
  typedef enum logic [3:0] {
    L_OFF = 4'b0001,
    L_IDLE = 4'b0010,
    L_RX = 4'b0100,
    L_HOLD = 4'b1000
  } lstate_t;
  typedef struct packed {
    logic [31:0] mode_reg;
    logic [31:0] listen_reg;
    logic [7:0] auto_reg;
    logic [15:0] timeout_reg;
    logic [31:0] freq_reg;
    lstate_t ls;
    logic [7:0] mult_cnt;
    logic [12:0] tick_cnt;
    logic [12:0] sub_cnt;
    logic in_transit;
    logic [15:0] to_bits;
    logic [3:0] to_step;
    logic level_seen;
    logic [3:0] pre_cnt;
    logic cal_busy;
    logic [12:0] cal_cnt;
    logic cal_done;
    logic qd_d;
    logic [1:0] sig_sync;
    logic [2:0] active_mode;
    logic rx_ready;
    logic sdata;
    logic tmo;
    logic discard;
    logic listen;
    logic [31:0] rdata;
    logic ack;
  } ds_t;
  ds_t s;
  ds_t next_s;
  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [12:0] base_ticks(input logic [1:0] code);
    unique case (code)
      BASE_4MS: base_ticks = 13'(BASE_4MS_IN_64US);
      BASE_262MS: base_ticks = 13'(BASE_262MS_IN_64US);
      default: base_ticks = 13'h0001;
    endcase
  endfunction : base_ticks
  function automatic logic trig_hit(input logic [1:0] code, input logic lvl, input logic sent,
                                    input logic chk, input logic fall);
    unique case (code)
      TRIG_LEVEL: trig_hit = lvl;
      TRIG_SENT: trig_hit = sent;
      TRIG_CHECK: trig_hit = chk;
      default: trig_hit = fall;
    endcase
  endfunction : trig_hit
  logic [2:0] mode_field;
  logic entry_hit;
  logic exit_hit;
  logic accepted;
  logic phase_end;
  logic wr;
  logic [2:0] wmode;
  always_comb begin
    mode_field = s.mode_reg[MODE_LSB +: 3];
    wr = link.wr_req && !s.ack;
    wmode = link.wdata[MODE_LSB +: 3];
    entry_hit = trig_hit(s.auto_reg[ENTRY_LSB +: 2], queue_level_flag, frame_sent_flag,
                         check_passed_flag, s.qd_d && !queue_has_data);
    exit_hit = trig_hit(s.auto_reg[EXIT_LSB +: 2], queue_level_flag, frame_sent_flag,
                        check_passed_flag, s.qd_d && !queue_has_data);
    // Sync match is only honoured once the bit clock had time to lock
    accepted = s.sig_sync[1] && (!s.listen_reg[ACCEPT_BIT] ||
               (sync_word_matched && s.pre_cnt == 4'(PREAMBLE_LOCK_BITS)));
    phase_end = (s.mult_cnt == 8'h01) && (s.tick_cnt == 13'h0001) && (s.sub_cnt == 13'h0001);
  end
  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.tmo = 1'b0;
    next_s.discard = 1'b0;
    next_s.qd_d = queue_has_data;
    next_s.sig_sync = {s.sig_sync[0], signal_above_limit};
    // Register access, one cycle answer
    if ((link.wr_req || link.rd_req) && !s.ack) begin
      next_s.ack = 1'b1;
      unique case (link.addr)
        OFS_MODE: next_s.rdata = s.mode_reg;
        OFS_LISTEN: next_s.rdata = s.listen_reg;
        OFS_AUTO: next_s.rdata = {24'h0, s.auto_reg};
        OFS_TIMEOUT: next_s.rdata = {16'h0, s.timeout_reg};
        OFS_FREQ: next_s.rdata = s.freq_reg;
        OFS_STATUS: next_s.rdata = {25'h0, s.active_mode, s.in_transit,
                                    s.ls != L_OFF, s.rx_ready, s.cal_done};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (link.addr)
        OFS_MODE: next_s.mode_reg = {26'h0, link.wdata[5:0]};
        OFS_LISTEN: next_s.listen_reg = {7'h0, link.wdata[24:0]};
        OFS_AUTO: next_s.auto_reg = link.wdata[7:0];
        OFS_TIMEOUT: next_s.timeout_reg = link.wdata[15:0];
        OFS_FREQ: next_s.freq_reg = link.wdata;
        OFS_OSC: begin
          if (link.wdata[0] && !s.cal_busy) begin
            next_s.cal_busy = 1'b1;
            next_s.cal_cnt = 13'(CAL_CYC);
            next_s.cal_done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Oscillator calibration
    if (s.cal_busy) begin
      next_s.cal_cnt = s.cal_cnt - 13'h0001;
      if (s.cal_cnt == 13'h0001) begin
        next_s.cal_busy = 1'b0;
        next_s.cal_done = 1'b1;
      end
    end
    // Phase tick divider from the calibrated RC time base
    if (s.ls == L_IDLE || s.ls == L_RX) begin
      if (s.sub_cnt != 13'h0001) begin
        next_s.sub_cnt = s.sub_cnt - 13'h0001;
      end else begin
        next_s.sub_cnt = 13'(BASE_64US_CYC);
        if (s.tick_cnt != 13'h0001) begin
          next_s.tick_cnt = s.tick_cnt - 13'h0001;
        end else if (s.mult_cnt != 8'h01) begin
          next_s.mult_cnt = s.mult_cnt - 8'h01;
          next_s.tick_cnt = base_ticks(s.ls == L_IDLE ? s.listen_reg[IDLE_BASE_LSB +: 2]
                                                      : s.listen_reg[RX_BASE_LSB +: 2]);
        end
      end
    end
    // Bit-period timeout and preamble lock count while receiving
    if (s.active_mode == MODE_RX && bit_tick) begin
      next_s.pre_cnt = (s.pre_cnt == 4'(PREAMBLE_LOCK_BITS)) ? s.pre_cnt : s.pre_cnt + 4'h1;
      next_s.to_step = s.to_step + 4'h1;
      if (s.to_step == 4'(TIMEOUT_BITS_PER_STEP - 1)) begin
        next_s.to_bits = s.to_bits + 16'h0001;
        if (s.to_bits + 16'h0001 == s.timeout_reg && s.timeout_reg != 16'h0) begin
          next_s.tmo = 1'b1;
        end
      end
    end
    if (s.sig_sync[1] && !s.level_seen && s.active_mode == MODE_RX) begin
      next_s.level_seen = 1'b1;
      next_s.to_bits = 16'h0;
      next_s.to_step = 4'h0;
    end
    // Listen engine
    unique case (s.ls)
      L_OFF: begin
        // Entry on the write itself, so a stopped listen never restarts on its own
        if (wr && link.addr == OFS_MODE && link.wdata[LISTEN_EN_BIT] && wmode == MODE_STANDBY &&
            !link.wdata[SEQ_OFF_BIT] && !link.wdata[ABORT_BIT] &&
            s.active_mode == MODE_STANDBY) begin
          next_s.ls = L_IDLE;
          next_s.mult_cnt = s.listen_reg[IDLE_MULT_LSB +: 8];
          next_s.tick_cnt = base_ticks(s.listen_reg[IDLE_BASE_LSB +: 2]);
          next_s.sub_cnt = 13'(BASE_64US_CYC);
          next_s.active_mode = MODE_SLEEP;
        end else if (s.active_mode != MODE_RX || !s.mode_reg[LISTEN_EN_BIT]) begin
          next_s.active_mode = s.in_transit ? s.auto_reg[TRANSIT_LSB +: 3] : mode_field;
        end
      end
      L_IDLE: begin
        if (phase_end) begin
          next_s.ls = L_RX;
          next_s.active_mode = MODE_RX;
          next_s.mult_cnt = s.listen_reg[RX_MULT_LSB +: 8];
          next_s.tick_cnt = base_ticks(s.listen_reg[RX_BASE_LSB +: 2]);
          next_s.discard = 1'b1;
        end
      end
      L_RX: begin
        if (accepted) begin
          if (s.listen_reg[END_LSB +: 2] == END_STAY) begin
            next_s.ls = L_OFF;
          end else begin
            next_s.ls = L_HOLD;
          end
        end else if (phase_end) begin
          next_s.ls = L_IDLE;
          next_s.active_mode = MODE_SLEEP;
          next_s.mult_cnt = s.listen_reg[IDLE_MULT_LSB +: 8];
          next_s.tick_cnt = base_ticks(s.listen_reg[IDLE_BASE_LSB +: 2]);
        end
      end
      L_HOLD: begin
        if (payload_complete_flag || s.tmo) begin
          if (s.listen_reg[END_LSB +: 2] == END_RESUME) begin
            next_s.ls = L_IDLE;
            next_s.active_mode = MODE_SLEEP;
            next_s.mult_cnt = s.listen_reg[IDLE_MULT_LSB +: 8];
            next_s.tick_cnt = base_ticks(s.listen_reg[IDLE_BASE_LSB +: 2]);
            next_s.sub_cnt = 13'(BASE_64US_CYC);
          end else begin
            next_s.ls = L_OFF;
            next_s.active_mode = mode_field;
          end
        end
      end
    endcase
    if (wr && link.addr == OFS_MODE && link.wdata[ABORT_BIT]) begin
      next_s.ls = L_OFF;
      next_s.active_mode = wmode;
    end
    // Auto transit, only outside listen
    if (s.ls == L_OFF && s.auto_reg[AUTO_EN_BIT]) begin
      if (!s.in_transit && entry_hit) begin
        next_s.in_transit = 1'b1;
      end else if (s.in_transit && exit_hit) begin
        next_s.in_transit = 1'b0;
      end
    end else if (!s.auto_reg[AUTO_EN_BIT]) begin
      next_s.in_transit = 1'b0;
    end
    if (next_s.active_mode != MODE_RX) begin
      next_s.level_seen = 1'b0;
      next_s.to_bits = 16'h0;
      next_s.to_step = 4'h0;
      next_s.pre_cnt = 4'h0;
    end
    next_s.rx_ready = (next_s.active_mode == MODE_RX);
    next_s.listen = (next_s.ls != L_OFF);
    // Without the bit synchroniser and packet mode, data follow the demodulator straight away
    next_s.sdata = s.rx_ready && (!s.listen_reg[BITSYNC_BIT] && !s.listen_reg[PACKET_BIT] ||
                   s.pre_cnt == 4'(PREAMBLE_LOCK_BITS)) && rx_bit;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{mode_reg: RESET_MODE_REG, listen_reg: RESET_LISTEN_REG, ls: L_OFF,
             cal_busy: 1'b1, cal_cnt: 13'(CAL_CYC), active_mode: MODE_STANDBY, default: '0};
    end else begin
      s <= next_s;
    end
  end
  assign link.rdata = s.rdata;
  assign link.ack = s.ack;
  assign active_mode = s.active_mode;
  assign receiver_ready_flag = s.rx_ready;
  assign serial_data_pin = s.sdata;
  assign listen_active = s.listen;
  assign timeout_irq = s.tmo;
  assign fifo_discard = s.discard;
  assign osc_cal_finished = s.cal_done;
endmodule : mode_seq_device

// ==== mode_seq_host.sv ====
// Host end: APB slave whose orders become device register accesses
module mode_seq_host
  import mode_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  mode_seq_if.host link
);
  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_WAIT = 3'b010,
    H_DONE = 3'b100
  } hstate_t;
  typedef struct packed {
    hstate_t st;
    logic wr_req;
    logic rd_req;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] prdata;
    logic pready;
  } hs_t;
  hs_t s;
  hs_t next_s;
  // Each APB access is forwarded as one device access, so the two-write
  // abort and the hop sequences are simply ordered APB writes by software.
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    unique case (s.st)
      H_IDLE: begin
        if (psel && !penable) begin
          next_s.addr = paddr;
          next_s.wdata = pwdata;
          next_s.wr_req = pwrite;
          next_s.rd_req = !pwrite;
          next_s.st = H_WAIT;
        end
      end
      H_WAIT: begin
        if (link.ack) begin
          next_s.wr_req = 1'b0;
          next_s.rd_req = 1'b0;
          next_s.prdata = link.rdata;
          next_s.pready = 1'b1;
          next_s.st = H_DONE;
        end
      end
      H_DONE: begin
        next_s.st = H_IDLE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: H_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = 1'b0;
  assign link.wr_req = s.wr_req;
  assign link.rd_req = s.rd_req;
  assign link.addr = s.addr;
  assign link.wdata = s.wdata;
endmodule : mode_seq_host

// ==== mode_seq_if.sv ====
// Interface joining the host end and the device end
interface mode_seq_if;
  logic wr_req;
  logic rd_req;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport device (input wr_req, input rd_req, input addr, input wdata, output rdata, output ack);
  modport host (output wr_req, output rd_req, output addr, output wdata, input rdata, input ack);
endinterface : mode_seq_if

// ==== mode_seq_pkg.sv ====
// Package of constants shared by both ends of the mode sequencer link
package mode_seq_pkg;
  // ***************************************************************
  // Mode encodings
  // ***************************************************************
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
  // ***************************************************************
  // Listen field codes
  // ***************************************************************
  localparam logic [1:0] BASE_64US = 2'h1;
  localparam logic [1:0] BASE_4MS = 2'h2;
  localparam logic [1:0] BASE_262MS = 2'h3;
  localparam logic [1:0] END_STAY = 2'h0;
  localparam logic [1:0] END_GO_MODE = 2'h1;
  localparam logic [1:0] END_RESUME = 2'h2;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_MHZ = 125;
  localparam int BASE_64US_NS = 64000;
  localparam int BASE_64US_CYC = BASE_64US_NS * CLK_MHZ / 1000;
  localparam int BASE_4MS_IN_64US = 64;
  localparam int BASE_262MS_IN_64US = 4096;
  localparam int PREAMBLE_LOCK_BITS = 12;
  localparam int TIMEOUT_BITS_PER_STEP = 16;
  localparam int CAL_CYC_DEFAULT = 4096;
  // ***************************************************************
  // Device register offsets (32-bit words, APB byte addresses)
  // ***************************************************************
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_LISTEN = 12'h004;
  localparam logic [11:0] OFS_AUTO = 12'h008;
  localparam logic [11:0] OFS_OSC = 12'h00c;
  localparam logic [11:0] OFS_TIMEOUT = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_FREQ = 12'h018;
  // Mode register fields
  localparam int MODE_LSB = 0;
  localparam int LISTEN_EN_BIT = 3;
  localparam int ABORT_BIT = 4;
  localparam int SEQ_OFF_BIT = 5;
  // Listen register fields
  localparam int IDLE_MULT_LSB = 0;
  localparam int RX_MULT_LSB = 8;
  localparam int IDLE_BASE_LSB = 16;
  localparam int RX_BASE_LSB = 18;
  localparam int ACCEPT_BIT = 20;
  localparam int END_LSB = 21;
  localparam int BITSYNC_BIT = 23;
  localparam int PACKET_BIT = 24;
  // Auto transit fields
  localparam int ENTRY_LSB = 0;
  localparam int EXIT_LSB = 2;
  localparam int TRANSIT_LSB = 4;
  localparam int AUTO_EN_BIT = 7;
  // Trigger codes
  localparam logic [1:0] TRIG_LEVEL = 2'h0;
  localparam logic [1:0] TRIG_SENT = 2'h1;
  localparam logic [1:0] TRIG_CHECK = 2'h2;
  localparam logic [1:0] TRIG_EMPTIED = 2'h3;
  // Status bits
  localparam int ST_CAL_DONE_BIT = 0;
  localparam int ST_RX_READY_BIT = 1;
  localparam int ST_LISTEN_BIT = 2;
  localparam int ST_TRANSIT_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam logic [31:0] RESET_MODE_REG = 32'h00000001;
  localparam logic [31:0] RESET_LISTEN_REG = 32'h00a21f01;
endpackage : mode_seq_pkg
